//--- hw/afc_pkg.sv
// package: constants and carriers for the fifo host controller
package afc_pkg;
	// ----------------------------------------
	// timing figures, derived cycle counts and word format
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100; // system clock period
	localparam int CLEAR_PULSE_WIDTH_NS = 400; // least master clear low time
	localparam int CLEAR_CYCLES = (CLEAR_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OVERLAP_NS = 100; // least overlap, standard grade
	localparam int OVERLAP_CYCLES = (OVERLAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FALL_THROUGH_TIME_US = 32; // standard grade fall-through
	localparam int FALL_THROUGH_CYCLES = FALL_THROUGH_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int WORD_W = 4; // word width
	localparam logic [WORD_W-1:0] WORD_RESET = 4'h0; // reset value of held words

	// ----------------------------------------
	// handshake phases
	// ----------------------------------------
	typedef enum logic [2:0] {
		AFC_CLEAR = 3'b000,
		AFC_IDLE = 3'b001,
		AFC_HIGH = 3'b010,
		AFC_WAITLOW = 3'b011,
		AFC_LOW = 3'b100
	} afc_phase_t;

	// a word offered to or returned from the host
	typedef struct packed {
		logic valid;
		logic [WORD_W-1:0] data;
	} afc_word_t;
endpackage : afc_pkg

//--- hw/afc_host.sv
// module: host controller that drives the self-timed fifo through its pins
`timescale 1ns/100ps
module afc_host #(
	parameter int FALL_CYCLES = afc_pkg::FALL_THROUGH_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// user write side
	input wire afc_pkg::afc_word_t wrReq,
	output logic wrReady,
	// user read side
	output afc_pkg::afc_word_t rdWord,
	// status
	output logic fifoFull,
	output logic fifoEmpty,
	// device pins
	output logic master_clear_n,
	output logic shiftIn,
	output logic [afc_pkg::WORD_W-1:0] word_in,
	input wire logic input_ready,
	output logic shiftOut,
	input wire logic output_ready,
	input wire logic [afc_pkg::WORD_W-1:0] word_out
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] inRdySync; // input ready chain
	logic [2:0] orSync; // output ready chain
	logic inRdyLvl; // filtered input ready
	logic orLvl; // filtered output ready
	logic [afc_pkg::WORD_W-1:0] qSync1; // data first stage
	logic [afc_pkg::WORD_W-1:0] qSync2; // data second stage

	// three flops; a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			inRdySync <= 3'h0;
			orSync <= 3'h0;
			inRdyLvl <= 1'b0;
			orLvl <= 1'b0;
			qSync1 <= afc_pkg::WORD_RESET;
			qSync2 <= afc_pkg::WORD_RESET;
		end else begin
			inRdySync <= {inRdySync[1:0], input_ready};
			orSync <= {orSync[1:0], output_ready};
			qSync1 <= word_out;
			qSync2 <= qSync1;
			if (inRdySync[1] == inRdySync[2]) begin
				inRdyLvl <= inRdySync[2];
			end
			if (orSync[1] == orSync[2]) begin
				orLvl <= orSync[2];
			end
		end
	end

	// ----------------------------------------
	// master clear pulse
	// ----------------------------------------
	logic [7:0] clrCnt; // cycles left of clear
	logic clearing; // clear still in progress

	// hold the clear low long enough, shift strobes low meanwhile
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clrCnt <= 8'(afc_pkg::CLEAR_CYCLES + 1);
			master_clear_n <= 1'b0;
			clearing <= 1'b1;
		end else if (clrCnt != 8'h0) begin
			clrCnt <= clrCnt - 8'h1;
			master_clear_n <= (clrCnt == 8'h1);
		end else begin
			master_clear_n <= 1'b1;
			clearing <= 1'b0;
		end
	end

	// ----------------------------------------
	// input handshake
	// ----------------------------------------
	afc_pkg::afc_phase_t inPhase; // write side phase
	logic [7:0] inCnt; // overlap counter
	logic [15:0] inRdyLowCnt; // time input ready low

	// load word, raise shift-in, wait for ready low, then hold both low
	always_ff @(posedge clk) begin
		if (sys_rst || clearing) begin
			inPhase <= afc_pkg::AFC_CLEAR;
			shiftIn <= 1'b0;
			word_in <= afc_pkg::WORD_RESET;
			wrReady <= 1'b0;
			inCnt <= 8'h0;
		end else begin
			case (inPhase)
				afc_pkg::AFC_CLEAR: begin
					inPhase <= afc_pkg::AFC_IDLE;
					wrReady <= 1'b1;
				end
				afc_pkg::AFC_IDLE: begin
					if (wrReq.valid && wrReady) begin
						word_in <= wrReq.data;
						wrReady <= 1'b0;
						inPhase <= afc_pkg::AFC_WAITLOW;
					end
				end
				afc_pkg::AFC_WAITLOW: begin
					// raise shift-in once the device is ready
					if (inRdyLvl && !shiftIn) begin
						shiftIn <= 1'b1;
						inCnt <= 8'h0;
						inPhase <= afc_pkg::AFC_HIGH;
					end
				end
				afc_pkg::AFC_HIGH: begin
					// keep shift-in high for the overlap, then until ready falls
					if (inCnt < 8'(afc_pkg::OVERLAP_CYCLES)) begin
						inCnt <= inCnt + 8'h1;
					end else if (!inRdyLvl) begin
						shiftIn <= 1'b0;
						inCnt <= 8'h0;
						inPhase <= afc_pkg::AFC_LOW;
					end
				end
				afc_pkg::AFC_LOW: begin
					// both low for the overlap; data may change now
					if (inCnt < 8'(afc_pkg::OVERLAP_CYCLES)) begin
						inCnt <= inCnt + 8'h1;
					end else begin
						wrReady <= 1'b1;
						inPhase <= afc_pkg::AFC_IDLE;
					end
				end
				default: begin
					inPhase <= afc_pkg::AFC_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// output handshake
	// ----------------------------------------
	afc_pkg::afc_phase_t outPhase; // read side phase
	logic [7:0] outCnt; // overlap counter
	logic [15:0] orLowCnt; // time output ready low

	// capture word while ready high, strobe shift-out, wait both low
	always_ff @(posedge clk) begin
		if (sys_rst || clearing) begin
			outPhase <= afc_pkg::AFC_IDLE;
			shiftOut <= 1'b0;
			rdWord <= '0;
			outCnt <= 8'h0;
		end else begin
			rdWord.valid <= 1'b0;
			case (outPhase)
				afc_pkg::AFC_IDLE: begin
					if (orLvl) begin
						rdWord.data <= qSync2;
						rdWord.valid <= 1'b1;
						shiftOut <= 1'b1;
						outCnt <= 8'h0;
						outPhase <= afc_pkg::AFC_HIGH;
					end
				end
				afc_pkg::AFC_HIGH: begin
					if (outCnt < 8'(afc_pkg::OVERLAP_CYCLES)) begin
						outCnt <= outCnt + 8'h1;
					end else if (!orLvl) begin
						shiftOut <= 1'b0;
						outCnt <= 8'h0;
						outPhase <= afc_pkg::AFC_LOW;
					end
				end
				afc_pkg::AFC_LOW: begin
					if (outCnt < 8'(afc_pkg::OVERLAP_CYCLES)) begin
						outCnt <= outCnt + 8'h1;
					end else begin
						outPhase <= afc_pkg::AFC_IDLE;
					end
				end
				default: begin
					outPhase <= afc_pkg::AFC_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// full and empty status
	// ----------------------------------------
	// ready low past the fall-through time reads as full or empty
	always_ff @(posedge clk) begin
		if (sys_rst || clearing) begin
			inRdyLowCnt <= 16'h0;
			orLowCnt <= 16'h0;
			fifoFull <= 1'b0;
			fifoEmpty <= 1'b0;
		end else begin
			if (inRdyLvl) begin
				inRdyLowCnt <= 16'h0;
			end else if (inRdyLowCnt < 16'(FALL_CYCLES)) begin
				inRdyLowCnt <= inRdyLowCnt + 16'h1;
			end
			if (orLvl) begin
				orLowCnt <= 16'h0;
			end else if (orLowCnt < 16'(FALL_CYCLES)) begin
				orLowCnt <= orLowCnt + 16'h1;
			end
			fifoFull <= !inRdyLvl && (inRdyLowCnt >= 16'(FALL_CYCLES));
			fifoEmpty <= !orLvl && (orLowCnt >= 16'(FALL_CYCLES));
		end
	end
endmodule : afc_host

//--- test/afc_host_properties.sv
// checker: pin handshake properties of the fifo host
`timescale 1ns/100ps
module afc_host_properties (
	// clock, reset and watched ports
	input wire logic clk,
	input wire logic sys_rst,
	input wire afc_pkg::afc_word_t rdWord,
	input wire logic master_clear_n,
	input wire logic shiftIn,
	input wire logic [afc_pkg::WORD_W-1:0] word_in,
	input wire logic input_ready,
	input wire logic shiftOut,
	input wire logic output_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	clr_width_a: assert property ($rose(master_clear_n) |-> !$past(master_clear_n, 4)) else $error("clr");
	clr_shift_a: assert property ($rose(master_clear_n) |-> !shiftIn) else $error("si clr");
	in_ready_a: assert property ($rose(shiftIn) |-> input_ready ##1 shiftIn) else $error("si hi");
	in_low_a: assert property ($fell(shiftIn) |-> !input_ready) else $error("si lo");
	data_hold_a: assert property (shiftIn |-> $stable(word_in)) else $error("data");
	out_hold_a: assert property ($rose(shiftOut) |-> output_ready ##1 shiftOut) else $error("so hi");
	out_low_a: assert property ($fell(shiftOut) |-> !output_ready) else $error("so lo");
	read_pulse_a: assert property (rdWord.valid |-> $rose(shiftOut) && output_ready ##1 !rdWord.valid) else $error("rd");
endmodule : afc_host_properties
bind afc_host afc_host_properties props (.clk(clk), .sys_rst(sys_rst), .rdWord(rdWord), .master_clear_n(master_clear_n),
	.shiftIn(shiftIn), .word_in(word_in), .input_ready(input_ready), .shiftOut(shiftOut), .output_ready(output_ready));

//--- test/afc_fifo_model.sv
// partner: behavioural model of the self-timed fifo device
`timescale 1ns/100ps
module afc_fifo_model #(parameter int DEPTH = 64, parameter int FALL = 4) (
	// clock, output stall and device pins
	input wire logic clk,
	input wire logic stall,
	input wire logic clrN,
	input wire logic sIn,
	input wire logic [3:0] dIn,
	output logic iRdy = 1'b0,
	input wire logic sOut,
	output logic oRdy = 1'b0,
	output logic [3:0] dOut = 4'h5
);
	logic [3:0] mem[$]; // head is the output cell
	logic busy = 1'b0; // output handshake open
	int ft = 0; // fall-through progress
	// clear wins, then both sides run on their own
	always @(posedge clk) begin
		if (!clrN) begin
			mem.delete();
			iRdy <= 1'b0;
			oRdy <= 1'b0;
			busy <= 1'b0;
			ft <= 0;
		end else begin
			if (iRdy && sIn) begin
				mem.push_back(dIn);
				iRdy <= 1'b0;
			end else if (!sIn && mem.size() < DEPTH)
				iRdy <= 1'b1;
			if (oRdy && sOut) begin
				oRdy <= 1'b0;
				busy <= 1'b1;
			end else if (busy && !sOut) begin
				busy <= 1'b0;
				dOut <= ~dOut; // released word is no longer shown
				void'(mem.pop_front());
				ft <= 0;
			end else if (!oRdy && !busy && mem.size() > 0 && !stall) begin
				ft <= ft + 1;
				if (ft == FALL) begin
					oRdy <= 1'b1;
					dOut <= mem[0];
				end
			end
		end
	end
endmodule : afc_fifo_model

//--- test/async_fallthrough_fifo_4bit_tb_top.sv
// bench: fifo host controller against the device model
`timescale 1ns/100ps
module async_fallthrough_fifo_4bit_tb_top;
	logic clk, sys_rst, stall, clrN, sIn, sOut, iRdy, oRdy, wrReady, full, empty;
	logic [3:0] dIn, dOut;
	afc_pkg::afc_word_t wrReq, rdWord;
	int err_count = 0, samples_checked = 0;
	logic [31:0] seed = 32'h2da7; // xorshift state
	logic [3:0] expQ[$]; // words in flight, oldest first
	afc_host #(.FALL_CYCLES(8)) DUT (.clk(clk), .sys_rst(sys_rst), .wrReq(wrReq), .wrReady(wrReady),
		.rdWord(rdWord), .fifoFull(full), .fifoEmpty(empty), .master_clear_n(clrN), .shiftIn(sIn),
		.word_in(dIn), .input_ready(iRdy), .shiftOut(sOut), .output_ready(oRdy), .word_out(dOut));
	afc_fifo_model partner (.clk(clk), .stall(stall), .clrN(clrN), .sIn(sIn), .dIn(dIn), .iRdy(iRdy),
		.sOut(sOut), .oRdy(oRdy), .dOut(dOut));
	function automatic logic [3:0] next_rand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[3:0];
	endfunction : next_rand
	task automatic check_val(input logic [3:0] got, input logic [3:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask : check_val
	// counts are compared at full width so no overflow can hide a loss
	task automatic check_count(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			err_count++;
			$display("FAIL %0t count %0d want %0d", $time, got, exp);
		end
	endtask : check_count
	task automatic give_verdict();
		$display("mismatches %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	// offer one word and hold it until the controller takes it
	task automatic write_word(input logic [3:0] d);
		int i;
		wrReq <= {1'b1, d};
		expQ.push_back(d);
		for (i = 0; i < 300 && wrReady !== 1'b1; i++)
			@(negedge clk);
		@(negedge clk);
		wrReq <= '0;
		@(negedge clk);
		if (i == 300) begin
			check_val(4'h0, 4'h1);
			give_verdict();
		end
	endtask : write_word
	// let the consumer side empty the device
	task automatic drain();
		int i;
		for (i = 0; i < 4000 && expQ.size() > 0; i++)
			@(negedge clk);
		repeat (40) @(negedge clk);
		check_count(expQ.size(), 0);
		check_val(4'(empty), 4'h1);
		if (i == 4000)
			give_verdict();
	endtask : drain
	// every delivered word must be the oldest one written
	always @(negedge clk)
		if (rdWord.valid === 1'b1)
			check_val(rdWord.data, expQ.size() ? expQ.pop_front() : 4'hx);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		sys_rst = 1'b1;
		wrReq = '0;
		stall = 1'b0;
		repeat (8) @(negedge clk);
		sys_rst = 1'b0;
		repeat (40) @(negedge clk);
		check_val(4'(empty), 4'h1);
		// random words while the output side stalls at random
		repeat (40) begin
			stall <= seed[9];
			write_word(next_rand());
		end
		stall <= 1'b0;
		drain();
		// fill all 64 places with boundary words at both ends
		stall <= 1'b1;
		write_word(4'h0);
		repeat (62) write_word(next_rand());
		write_word(4'hf);
		repeat (30) @(negedge clk);
		check_val(4'(full), 4'h1);
		stall <= 1'b0;
		drain();
		give_verdict();
	end
endmodule : async_fallthrough_fifo_4bit_tb_top
